// ===== tb_top.sv
// Self-checking bench for the modem handshake pin block.
// Assumes one 100 MHz clock; this module is the AXI4-Lite master.
`timescale 1ns/1ps

module tb_top;
    import ump_pkg::*;

    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, mctl;
    logic [3:0]  wstrb = 4'h1;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, ien, drv;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  lines = 4'hf, nl, dlt, ist, msk, clr;
    logic        rxd_lvl = 1'b1, strap_lvl = 1'b0, tx_bit = 1'b1;
    logic        dcd_n, ri_n, dsr_n, cts_n, rxd, rts_pad, rts_n, rts_oe_n;
    logic        txd, rx_bit, strap_q, irq;
    logic [15:0] base;
    int          error_cnt = 0, comparisons = 0, cyc = 0;

    // Free-running 100 MHz clock
    always #5 aclk = ~aclk;

    ump_modem_pins ump_modem_pins_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .carrier_detect_n(dcd_n), .set_ready_n(dsr_n), .clear_send_n(cts_n),
        .ring_indicate_n(ri_n), .request_send_in(rts_pad), .request_send_n(rts_n),
        .request_send_oe_n(rts_oe_n), .serial_receive_in(rxd), .serial_transmit_out(txd),
        .tx_bit_in(tx_bit), .rx_bit_out(rx_bit), .config_base_strap(strap_q),
        .config_base_addr(base), .irq(irq)
    );

    ump_modem_model ump_modem_model_i (
        .line_lvl(lines), .rxd_lvl(rxd_lvl), .strap_lvl(strap_lvl), .rts_n(rts_n),
        .rts_oe_n(rts_oe_n), .dcd_n(dcd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n),
        .rxd(rxd), .rts_pad(rts_pad)
    );

    // Expected status word: line states on top, rise bits below
    function automatic logic [31:0] mstat_exp(input logic [3:0] l, input logic [3:0] dl);
        return {24'h0, ~l, dl};
    endfunction

    // Expected interrupt level from enable, sticky changes and mask
    function automatic logic irq_exp(input logic en, input logic [3:0] st, input logic [3:0] m);
        return en & (|(st & m));
    endfunction

    // Expected request pin: loop mode overrides the control bit
    function automatic logic rts_exp(input logic [7:0] c);
        return c[4] | ~c[1];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("TB: %0d comparisons, %0d errors", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Address and data offered together; each dropped once its own ready is seen
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dw, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= dw;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] dr, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        dr = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dw);
        logic [1:0] rs;
        axi_wr(a, dw, rs);
        chk(rs, RESP_OKAY);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] dr;
        logic [1:0]  rs;
        axi_rd(a, dr, rs);
        chk(rs, RESP_OKAY);
        chk(dr, exp);
    endtask

    // Reset for six cycles with the chosen strap level on the pad
    task automatic do_reset(input logic s);
        @(posedge aclk);
        aresetn <= 1'b0;
        strap_lvl <= s;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    // Cut a hang short; the run needs under two thousand cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    // Main sequence: resets and strap, then random line traffic, then bad addresses
    initial begin
        void'($urandom(32'h37d1));
        do_reset(1'b0);
        chk(base, CFG_BASE_LOW);
        chk(rts_n, 1'b1);
        chk(rts_oe_n, 1'b1);
        wr(OFS_MCTL, 32'h2);
        wr(OFS_CFG, 32'h1);
        repeat (2) @(posedge aclk);
        chk(rts_pad, 1'b0);
        do_reset(1'b1);
        chk(rts_n, 1'b1);
        chk(rts_oe_n, 1'b1);
        chk(base, CFG_BASE_HIGH);
        chk(strap_q, 1'b1);
        dlt = 4'h0;
        ist = 4'h0;
        for (int i = 0; i < 40; i++) begin
            mctl = {3'h0, 1'($urandom), 2'h0, 1'($urandom), 1'b0};
            ien = 1'($urandom);
            msk = 4'($urandom);
            drv = 1'($urandom);
            wr(OFS_MCTL, {24'h0, mctl});
            wr(OFS_IER, {28'h0, ien, 3'h0});
            wr(OFS_IMASK, {28'h0, msk});
            wr(OFS_CFG, {31'h0, drv});
            @(posedge aclk);
            // Every eighth pass flips all four lines at once
            nl = (i % 8 == 0) ? ~lines : 4'($urandom);
            lines <= nl;
            tx_bit <= 1'($urandom);
            rxd_lvl <= 1'($urandom);
            dlt = dlt | (~lines & nl);
            ist = ist | (lines ^ nl);
            repeat (2) @(posedge aclk);
            chk(irq, irq_exp(ien, ist, msk));
            chk(rts_n, rts_exp(mctl));
            chk(rts_oe_n, !drv);
            chk(txd, mctl[4] ? 1'b1 : tx_bit);
            chk(rx_bit, mctl[4] ? tx_bit : rxd_lvl);
            rd_chk(OFS_MSTAT, mstat_exp(lines, dlt));
            dlt = 4'h0;
            rd_chk(OFS_MSTAT, mstat_exp(lines, dlt));
            rd_chk(OFS_CFG, {30'h0, 1'b1, drv});
            rd_chk(OFS_IST, {28'h0, ist});
            clr = 4'($urandom);
            wr(OFS_IST, {28'h0, clr});
            ist = ist & ~clr;
            repeat (2) @(posedge aclk);
            chk(irq, irq_exp(ien, ist, msk));
        end
        // A write with lane 0 off is acknowledged but must leave the register alone
        wstrb <= 4'h0;
        axi_wr(OFS_MCTL, {24'h0, ~mctl}, r);
        chk(r, RESP_OKAY);
        wstrb <= 4'h1;
        rd_chk(OFS_MCTL, {24'h0, mctl});
        axi_rd(8'h18, d, r);
        chk(r, RESP_SLVERR);
        chk(d, 32'h0);
        axi_wr(8'h1c, 32'hff, r);
        chk(r, RESP_SLVERR);
        finish_test();
    end
endmodule // tb_top

// ===== ump_modem_model.sv
// Behavioural far-end modem: drives the handshake lines and the receive line.
// Assumes the bench sets line levels; the strap is a resistor on the request pad.
`timescale 1ns/1ps

module ump_modem_model (
    input  wire logic [3:0] line_lvl,  // Lines {dcd, ri, dsr, cts}, low active
    input  wire logic       rxd_lvl,   // Level sent on the receive line
    input  wire logic       strap_lvl, // Pull level on the request pad
    input  wire logic       rts_n,     // Request to send from the port
    input  wire logic       rts_oe_n,  // Port drive enable, low
    output logic            dcd_n,     // Carrier detect
    output logic            ri_n,      // Ring indicate
    output logic            dsr_n,     // Data set ready
    output logic            cts_n,     // Clear to send
    output logic            rxd,       // Receive data line
    output logic            rts_pad    // Resolved pad level
);
    // Handshake lines and receive data come from the modem side
    assign {dcd_n, ri_n, dsr_n, cts_n} = line_lvl;
    assign rxd = rxd_lvl;
    // Pad follows the port when driven, otherwise the strap resistor sets it
    assign rts_pad = rts_oe_n ? strap_lvl : rts_n;
endmodule // ump_modem_model

// ===== ump_modem_pins.sv
// Modem handshake and serial pin logic of a UART port, with AXI4-Lite registers.
// Assumes pin inputs are already synchronous to aclk and the pad ring
// resolves the request-to-send pin from its output enable.
`timescale 1ns/1ps

module ump_modem_pins
    import ump_pkg::*;
(
    input  wire logic              aclk,                // 100 MHz clock
    input  wire logic              aresetn,             // Synchronous reset, low
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,        // Write address
    input  wire logic              s_axi_awvalid,       // Write address valid
    output logic                   s_axi_awready,       // Write address ready
    input  wire logic [AXI_DW-1:0] s_axi_wdata,         // Write data
    input  wire logic [3:0]        s_axi_wstrb,         // Write strobes
    input  wire logic              s_axi_wvalid,        // Write data valid
    output logic                   s_axi_wready,        // Write data ready
    output logic [1:0]             s_axi_bresp,         // Write response
    output logic                   s_axi_bvalid,        // Write response valid
    input  wire logic              s_axi_bready,        // Write response ready
    input  wire logic [AXI_AW-1:0] s_axi_araddr,        // Read address
    input  wire logic              s_axi_arvalid,       // Read address valid
    output logic                   s_axi_arready,       // Read address ready
    output logic [AXI_DW-1:0]      s_axi_rdata,         // Read data
    output logic [1:0]             s_axi_rresp,         // Read response
    output logic                   s_axi_rvalid,        // Read data valid
    input  wire logic              s_axi_rready,        // Read data ready
    input  wire logic              carrier_detect_n,    // Carrier detect, low
    input  wire logic              set_ready_n,         // Data set ready, low
    input  wire logic              clear_send_n,        // Clear to send, low
    input  wire logic              ring_indicate_n,     // Ring indicate, low
    input  wire logic              request_send_in,     // Pin level, strap source
    output logic                   request_send_n,      // Request to send, low
    output logic                   request_send_oe_n,   // Pin drive enable, low
    input  wire logic              serial_receive_in,   // Receive data pin
    output logic                   serial_transmit_out, // Transmit data pin
    input  wire logic              tx_bit_in,           // Serial bit from shifter
    output logic                   rx_bit_out,          // Serial bit to shifter
    output logic                   config_base_strap,   // Sampled strap level
    output logic [15:0]            config_base_addr,    // Selected config base
    output logic                   irq                  // Interrupt, high level
);

    ump_state_t st_q;
    ump_state_t st_d;
    logic [3:0] pins_n;

    // Map a byte address to a register; shared by both bus channels
    function automatic ump_sel_t dec_f(input logic [AXI_AW-1:0] a);
        case (a)
            OFS_MSTAT: dec_f = SEL_MSTAT;
            OFS_MCTL:  dec_f = SEL_MCTL;
            OFS_IER:   dec_f = SEL_IER;
            OFS_CFG:   dec_f = SEL_CFG;
            OFS_IST:   dec_f = SEL_IST;
            OFS_IMASK: dec_f = SEL_IMASK;
            default:   dec_f = SEL_NONE;
        endcase
    endfunction

    // Pin vector ordered like the change bits: dcd, ri, dsr, cts
    assign pins_n = {carrier_detect_n, ring_indicate_n, set_ready_n, clear_send_n};

    // Next-state logic for bus, status, control and pins
    always_comb begin
        logic [3:0] rise;
        logic [3:0] chg;
        logic [3:0] ist_clr;
        logic       wr_do;
        logic       rd_do;
        ump_sel_t   wsel;
        ump_sel_t   rsel;
        logic [7:0] rbyte;
        rise    = NIB_ZERO;
        chg     = NIB_ZERO;
        ist_clr = NIB_ZERO;
        wr_do   = 1'b0;
        rd_do   = 1'b0;
        wsel    = SEL_NONE;
        rsel    = SEL_NONE;
        rbyte   = BYTE_ZERO;
        st_d    = st_q;

        // Write channels are taken independently, in either order
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (s_axi_awvalid && st_q.awready) begin
            st_d.aw_have = 1'b1;
            st_d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_q.wready) begin
            st_d.w_have = 1'b1;
            st_d.wbyte  = s_axi_wdata[7:0];
            st_d.wlane  = s_axi_wstrb[0];
        end
        if (st_d.aw_have && st_d.w_have && !st_d.bvalid) begin
            wr_do        = st_d.wlane;
            wsel         = dec_f(st_d.awaddr);
            st_d.aw_have = 1'b0;
            st_d.w_have  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = (dec_f(st_d.awaddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        // One outstanding write; new address and data wait for the response
        st_d.awready = !st_d.aw_have && !st_d.bvalid;
        st_d.wready  = !st_d.w_have && !st_d.bvalid;

        // Read channel answers one cycle after the address is taken
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_q.arready) begin
            rd_do = 1'b1;
            rsel  = dec_f(s_axi_araddr);
            case (rsel)
                SEL_MSTAT: rbyte = {~pins_n, st_q.delta};
                SEL_MCTL:  rbyte = st_q.mctl;
                SEL_IER:   rbyte = st_q.ier;
                SEL_CFG:   rbyte = {6'h00, st_q.strap, st_q.drive_en};
                SEL_IST:   rbyte = {4'h0, st_q.ist};
                SEL_IMASK: rbyte = {4'h0, st_q.imask};
                default:   rbyte = BYTE_ZERO;
            endcase
            st_d.rvalid = 1'b1;
            st_d.rdata  = {24'h000000, rbyte};
            st_d.rresp  = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        st_d.arready = !st_d.rvalid;

        // Pin edges: a pin rising after the last status read sets its change bit
        rise          = pins_n & ~st_q.pin_prev;
        chg           = pins_n ^ st_q.pin_prev;
        st_d.pin_prev = pins_n;
        // Clear on read, but an edge in the same cycle survives
        if (rd_do && rsel == SEL_MSTAT) begin
            st_d.delta = NIB_ZERO;
        end
        st_d.delta = st_d.delta | rise;

        // Control register writes; only the low byte lane carries data
        if (wr_do) begin
            case (wsel)
                SEL_MCTL:  st_d.mctl     = st_d.wbyte;
                SEL_IER:   st_d.ier      = st_d.wbyte;
                SEL_CFG:   st_d.drive_en = st_d.wbyte[CFG_DRIVE];
                SEL_IST:   ist_clr       = st_d.wbyte[3:0];
                SEL_IMASK: st_d.imask    = st_d.wbyte[3:0];
                default:   ist_clr       = NIB_ZERO;
            endcase
        end
        // Sticky change events; a new change beats a write-one clear
        st_d.ist = (st_q.ist & ~ist_clr) | chg;
        st_d.irq = st_d.ier[IER_MS] && ((st_d.ist & st_d.imask) != NIB_ZERO);

        // Request to send: inactive in loop mode, tri-stated until enabled
        st_d.rts_n    = !(st_d.mctl[MCT_RTS] && !st_d.mctl[MCT_LOOP]);
        st_d.rts_oe_n = !st_d.drive_en;

        // Loop mode keeps the line idle and turns transmit data back inward
        st_d.tx = st_d.mctl[MCT_LOOP] ? 1'b1 : tx_bit_in;
        st_d.rx = st_d.mctl[MCT_LOOP] ? tx_bit_in : serial_receive_in;

        // Strap is read at the first edge after reset, pin still undriven
        if (!st_q.strap_done) begin
            st_d.strap_done = 1'b1;
            st_d.strap      = request_send_in;
            st_d.cfg_base   = request_send_in ? CFG_BASE_HIGH : CFG_BASE_LOW;
        end
    end

    // State register; reset leaves the pin high and undriven
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs taken straight from the state register
    assign s_axi_awready       = st_q.awready;
    assign s_axi_wready        = st_q.wready;
    assign s_axi_bresp         = st_q.bresp;
    assign s_axi_bvalid        = st_q.bvalid;
    assign s_axi_arready       = st_q.arready;
    assign s_axi_rdata         = st_q.rdata;
    assign s_axi_rresp         = st_q.rresp;
    assign s_axi_rvalid        = st_q.rvalid;
    assign request_send_n      = st_q.rts_n;
    assign request_send_oe_n   = st_q.rts_oe_n;
    assign serial_transmit_out = st_q.tx;
    assign rx_bit_out          = st_q.rx;
    assign config_base_strap   = st_q.strap;
    assign config_base_addr    = st_q.cfg_base;
    assign irq                 = st_q.irq;

    // Checks; all share the one clock, and all but AST_RTS_RESET are disabled in reset
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence mstat_read_s;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr == OFS_MSTAT);
    endsequence

    sequence dcd_rise_s;
        carrier_detect_n && !$past(carrier_detect_n);
    endsequence

    sequence dsr_rise_s;
        set_ready_n && !$past(set_ready_n);
    endsequence

    AST_DCD_STATE: assert property (mstat_read_s |=> s_axi_rvalid &&
        (s_axi_rdata[MST_DCD] == !$past(carrier_detect_n)))
        else $error("Carrier state not shown in status bit 7");

    AST_DCD_DELTA: assert property (dcd_rise_s |=> st_q.delta[MST_DDCD])
        else $error("Carrier rise did not set change bit");

    AST_DCD_IRQ: assert property ($changed(carrier_detect_n) && st_q.ier[IER_MS]
        && $stable(st_q.ier) && st_q.imask[MST_DDCD] && $stable(st_q.imask) |=> irq)
        else $error("Carrier change gave no interrupt");

    AST_DSR_STATE: assert property (mstat_read_s |=>
        (s_axi_rdata[MST_DSR] == !$past(set_ready_n)))
        else $error("Set ready state not shown in status bit 5");

    AST_DSR_DELTA: assert property (dsr_rise_s |=> st_q.delta[MST_DDSR])
        else $error("Set ready rise did not set change bit");

    AST_DSR_IRQ: assert property ($changed(set_ready_n) && st_q.ier[IER_MS]
        && $stable(st_q.ier) && st_q.imask[MST_DDSR] && $stable(st_q.imask) |=> irq)
        else $error("Set ready change gave no interrupt");

    AST_RTS_FOLLOW: assert property (!st_q.mctl[MCT_LOOP] |->
        (request_send_n == !st_q.mctl[MCT_RTS]))
        else $error("Request to send does not follow control bit");

    AST_RTS_RESET: assert property (disable iff (1'b0)
        !aresetn |=> request_send_n && request_send_oe_n)
        else $error("Request to send not idle after reset");

    AST_RTS_LOOP: assert property (st_q.mctl[MCT_LOOP] |-> request_send_n)
        else $error("Request to send active in loop mode");

    AST_RTS_TRISTATE: assert property (!st_q.drive_en |-> request_send_oe_n)
        else $error("Pin driven before drive enable");

    AST_STRAP: assert property ($rose(st_q.strap_done) |->
        (config_base_strap == $past(request_send_in)) &&
        (config_base_addr == ($past(request_send_in) ? CFG_BASE_HIGH : CFG_BASE_LOW)))
        else $error("Strap not captured into base select");

    AST_SERIAL: assert property (!st_q.mctl[MCT_LOOP] && $stable(st_q.mctl) |->
        (serial_transmit_out == $past(tx_bit_in)) && (rx_bit_out == $past(serial_receive_in)))
        else $error("Serial pins not passed through");

    AST_CTS_DELTA: assert property (clear_send_n && !$past(clear_send_n)
        |=> st_q.delta[MST_DCTS])
        else $error("Clear to send rise did not set change bit");

    AST_RI_DELTA: assert property (ring_indicate_n && !$past(ring_indicate_n)
        |=> st_q.delta[MST_TERI])
        else $error("Ring rise did not set change bit");

    AST_READ_CLEAR: assert property (mstat_read_s ##0 ($past(pins_n) == pins_n)
        ##1 ((pins_n & ~$past(pins_n)) == NIB_ZERO) |-> (st_q.delta == NIB_ZERO))
        else $error("Status read left change bits set");

endmodule // ump_modem_pins

// ===== ump_pkg.sv
// Constants, register map and state layout for the modem handshake pin block.
// Assumes a 32-bit AXI4-Lite master and a single 100 MHz clock domain.
package ump_pkg;

    // Bus geometry
    localparam int          AXI_AW       = 8;
    localparam int          AXI_DW       = 32;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Register byte offsets
    localparam logic [7:0]  OFS_MSTAT    = 8'h00;
    localparam logic [7:0]  OFS_MCTL     = 8'h04;
    localparam logic [7:0]  OFS_IER      = 8'h08;
    localparam logic [7:0]  OFS_CFG      = 8'h0c;
    localparam logic [7:0]  OFS_IST      = 8'h10;
    localparam logic [7:0]  OFS_IMASK    = 8'h14;

    // Modem status layout: line states in the upper nibble, change bits below
    localparam int          MST_DCD      = 7;
    localparam int          MST_RI       = 6;
    localparam int          MST_DSR      = 5;
    localparam int          MST_CTS      = 4;
    localparam int          MST_DDCD     = 3;
    localparam int          MST_TERI     = 2;
    localparam int          MST_DDSR     = 1;
    localparam int          MST_DCTS     = 0;

    // Modem control, interrupt enable and configuration fields
    localparam int          MCT_RTS      = 1;
    localparam int          MCT_LOOP     = 4;
    localparam int          IER_MS       = 3;
    localparam int          CFG_DRIVE    = 0;
    localparam int          CFG_STRAP    = 1;

    // Configuration base addresses chosen by the strap
    localparam logic [15:0] CFG_BASE_LOW  = 16'h0100;
    localparam logic [15:0] CFG_BASE_HIGH = 16'h0200;

    // Reset values
    localparam logic [3:0]  PINS_IDLE    = 4'hf;
    localparam logic [3:0]  NIB_ZERO     = 4'h0;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;

    // Register select
    typedef enum {
        SEL_MSTAT,
        SEL_MCTL,
        SEL_IER,
        SEL_CFG,
        SEL_IST,
        SEL_IMASK,
        SEL_NONE
    } ump_sel_t;

    // Whole state of the block
    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              aw_have;
        logic              w_have;
        logic [AXI_AW-1:0] awaddr;
        logic [7:0]        wbyte;
        logic              wlane;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [AXI_DW-1:0] rdata;
        logic [1:0]        rresp;
        logic [3:0]        pin_prev;
        logic [3:0]        delta;
        logic [7:0]        mctl;
        logic [7:0]        ier;
        logic              drive_en;
        logic [3:0]        ist;
        logic [3:0]        imask;
        logic              irq;
        logic              rts_n;
        logic              rts_oe_n;
        logic              strap_done;
        logic              strap;
        logic [15:0]       cfg_base;
        logic              rx;
        logic              tx;
    } ump_state_t;

    localparam ump_state_t ST_RESET = '{
        awready: 1'b1, wready: 1'b1, aw_have: 1'b0, w_have: 1'b0,
        awaddr: 8'h00, wbyte: 8'h00, wlane: 1'b0, bvalid: 1'b0,
        bresp: 2'h0, arready: 1'b1, rvalid: 1'b0, rdata: 32'h0000_0000,
        rresp: 2'h0, pin_prev: 4'hf, delta: 4'h0, mctl: 8'h00,
        ier: 8'h00, drive_en: 1'b0, ist: 4'h0, imask: 4'h0,
        irq: 1'b0, rts_n: 1'b1, rts_oe_n: 1'b1, strap_done: 1'b0,
        strap: 1'b0, cfg_base: 16'h0100, rx: 1'b1, tx: 1'b1
    };

endpackage : ump_pkg
